// *** rtl/uart_de_consts.svh ***
// What this block does
// - With flow control, driver enable asserts 2 clocks to 2 clocks plus a bit after clear-to-send falls.
// - Start bit falls one bit period, at most one clock more, after driver enable asserts.
// - Driver enable drops one to two clocks after the last stop bit ends.
// - Without flow control, a write of a character asserts driver enable.
// - Without flow control, or with clear-to-send low, a character written before the current one ends keeps driver enable asserted throughout.
// - With flow control, a loaded character waits until clear-to-send is low.
// - Driver enable polarity is selectable, active high or active low.
//
// constants for the driver-enable transmit sequencer
// assumes a 100 MHz reference clock
`ifndef UART_DE_CONSTS_SVH
`define UART_DE_CONSTS_SVH

// ==========================================
// timing in its own units
`define UDE_CLK_PERIOD_NS 10
`define UDE_BIT_PERIOD_NS 8680
`define UDE_CTS_DLY_NS    20
`define UDE_TAIL_NS       10

// ==========================================
// derived cycle counts (least times round up)
`define UDE_BIT_CLKS  (`UDE_BIT_PERIOD_NS / `UDE_CLK_PERIOD_NS)
`define UDE_CTS_CLKS  ((`UDE_CTS_DLY_NS + `UDE_CLK_PERIOD_NS - 1) / `UDE_CLK_PERIOD_NS)
`define UDE_TAIL_CLKS ((`UDE_TAIL_NS + `UDE_CLK_PERIOD_NS - 1) / `UDE_CLK_PERIOD_NS)

// ==========================================
// frame and buffer shape
`define UDE_DATA_BITS  8
`define UDE_FIFO_DEPTH 32
`define UDE_LINE_IDLE  1'h1
`define UDE_START_LVL  1'h0
`define UDE_STOP_LVL   1'h1

`endif

// *** rtl/uart_de_pkg.sv ***
// types for the driver-enable transmit sequencer
// assumes nothing beyond the constants header
package uart_de_pkg;

  // line sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_START,
    ST_DATA,
    ST_STOP,
    ST_TAIL
  } txState_t;

endpackage

// *** rtl/uart_de_fifo.sv ***
// character buffer between the writer and the line sequencer
// assumes one clock, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module uart_de_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             wrValid,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  wrReady,
  // draining side
  output logic                  rdValid,
  output logic      [WIDTH-1:0] rdData,
  input  wire logic             rdReady
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             doWrite;
  logic             doRead;

  // full when pointers differ only in the wrap bit
  assign wrReady = (wrPtr ^ rdPtr) != {1'h1, {AW{1'h0}}};
  assign rdValid = wrPtr != rdPtr;
  assign rdData  = mem[rdPtr[AW-1:0]];
  assign doWrite = wrValid && wrReady;
  assign doRead  = rdValid && rdReady;

  // storage
  always_ff @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= wrData;
    end
  end

  // pointers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'h1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'h1;
      end
    end
  end

  chk_fifo_level_step: assert property (@(posedge ref_clk) disable iff (!rstn)
    doWrite && !doRead |=> (wrPtr - rdPtr) == $past(wrPtr - rdPtr) + 1'h1)
    else $error("fifo level did not grow on write");

endmodule
`default_nettype wire

// *** rtl/uart_bit_div.sv ***
// bit-period divider giving a one-cycle tick
// assumes restart is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`default_nettype none
module uart_bit_div #(
  parameter int BIT_CLKS = 868
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // control
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = $clog2(BIT_CLKS);
  localparam logic [CW-1:0] RELOAD = CW'(BIT_CLKS - 1);

  if (BIT_CLKS < 2) begin : g_bad_div
    $error("bit period must be at least two clocks");
  end

  logic [CW-1:0] count;

  assign tick = (count == '0) && !restart;

  // down counter, reloaded on restart and at each tick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (restart || count == '0) begin
      count <= RELOAD;
    end else begin
      count <= count - 1'h1;
    end
  end

endmodule
`default_nettype wire

// *** rtl/uart_driver_enable_flow_control.sv ***
// transmit sequencer driving a half-duplex transceiver enable
// assumes inputs synchronous to ref_clk, writer uses txWrite/txReady
`timescale 1ns/1ps
`default_nettype none
`include "uart_de_consts.svh"
module uart_driver_enable_flow_control #(
  parameter int DATA_BITS  = `UDE_DATA_BITS,
  parameter int BIT_CLKS   = `UDE_BIT_CLKS,
  parameter int FIFO_DEPTH = `UDE_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // character writes
  input  wire logic                 txWrite,
  input  wire logic [DATA_BITS-1:0] txData,
  output logic                      txReady,
  // configuration
  input  wire logic                 ctsEnable,
  input  wire logic                 dePolarity,
  input  wire logic                 stopTwo,
  // line side
  input  wire logic                 ctsN,
  output logic                      txd,
  output logic                      driverEnable,
  // status
  output uart_de_pkg::txState_t     lineState
);
  import uart_de_pkg::*;

  localparam int IW = $clog2(DATA_BITS);
  localparam int CD = `UDE_CTS_CLKS;

  if (DATA_BITS < 2) begin : g_bad_bits
    $error("at least two data bits are needed");
  end
  if (CD < 2) begin : g_bad_cts
    $error("clear-to-send delay must be two clocks or more");
  end

  // ==========================================
  // start permission

  // a character may go out when one waits and the line is clear
  function automatic logic canStart(input logic have, input logic useCts,
                                    input logic ctsLow);
    canStart = have && (!useCts || ctsLow);
  endfunction

  // ==========================================
  // declarations
  txState_t             state;
  txState_t             next_state;
  logic                 fifoValid;
  logic [DATA_BITS-1:0] fifoData;
  logic                 pop;
  logic                 bitTick;
  logic                 restart;
  logic [CD-1:0]        ctsPipe;
  logic                 ctsLow;
  logic [DATA_BITS-1:0] shiftReg;
  logic [IW-1:0]        bitIdx;
  logic                 stopIdx;
  logic                 lastData;
  logic                 lastStop;
  logic                 goNext;
  logic                 deOn;
  logic [31:0]          leadCnt;

  // ==========================================
  // character buffer
  uart_de_fifo #(
    .WIDTH (DATA_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wrValid (txWrite),
    .wrData  (txData),
    .wrReady (txReady),
    .rdValid (fifoValid),
    .rdData  (fifoData),
    .rdReady (pop)
  );

  // ==========================================
  // bit timing
  uart_bit_div #(
    .BIT_CLKS (BIT_CLKS)
  ) u_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .restart (restart),
    .tick    (bitTick)
  );

  // ==========================================
  // clear-to-send delay line
  // fixed delay gives the two-clock least lag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctsPipe <= '1;
    end else begin
      ctsPipe <= {ctsPipe[CD-2:0], ctsN};
    end
  end

  assign ctsLow   = !ctsPipe[CD-1];
  assign lastData = bitIdx == IW'(DATA_BITS - 1);
  assign lastStop = stopIdx == stopTwo;
  assign goNext   = canStart(fifoValid, ctsEnable, ctsLow);

  // ==========================================
  // sequencer next state
  always_comb begin
    next_state = state;
    pop        = 1'h0;
    case (state)
      ST_IDLE: begin
        // wait for a character and, if used, clear-to-send
        if (goNext) begin
          next_state = ST_LEAD;
          pop        = 1'h1;
        end
      end
      ST_LEAD: begin
        // one bit period of enable before the start edge
        if (bitTick) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (bitTick) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (bitTick && lastData) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // chain the next character without dropping enable
        if (bitTick && lastStop) begin
          if (goNext) begin
            next_state = ST_START;
            pop        = 1'h1;
          end else begin
            next_state = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // divider restarts as enable rises
  assign restart = (state == ST_IDLE) && (next_state == ST_LEAD);

  // ==========================================
  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // status copy of the state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lineState <= ST_IDLE;
    end else begin
      lineState <= next_state;
    end
  end

  // ==========================================
  // character shifting
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shiftReg <= '0;
    end else if (pop) begin
      shiftReg <= fifoData;
    end else if (state == ST_DATA && bitTick) begin
      shiftReg <= shiftReg >> 1;
    end
  end

  // data bit index
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bitIdx <= '0;
    end else if (state == ST_START) begin
      bitIdx <= '0;
    end else if (state == ST_DATA && bitTick) begin
      bitIdx <= bitIdx + 1'h1;
    end
  end

  // stop bit index
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stopIdx <= 1'h0;
    end else if (state != ST_STOP) begin
      stopIdx <= 1'h0;
    end else if (bitTick) begin
      stopIdx <= 1'h1;
    end
  end

  // ==========================================
  // serial line, lsb first
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txd <= `UDE_LINE_IDLE;
    end else if (next_state == ST_START && state != ST_START) begin
      txd <= `UDE_START_LVL;
    end else if (state == ST_START && bitTick) begin
      txd <= shiftReg[0];
    end else if (state == ST_DATA && bitTick) begin
      txd <= lastData ? `UDE_STOP_LVL : shiftReg[1];
    end
  end

  // ==========================================
  // driver enable
  // held on through tail so release comes a clock after the stop bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      deOn <= 1'h0;
    end else begin
      deOn <= next_state != ST_IDLE;
    end
  end

  // pin level follows the chosen polarity
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      driverEnable <= 1'h0;
    end else begin
      driverEnable <= (next_state != ST_IDLE) == dePolarity;
    end
  end

  // ==========================================
  // checking helpers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      leadCnt <= '0;
    end else if (state == ST_LEAD) begin
      leadCnt <= leadCnt + 32'h1;
    end else begin
      leadCnt <= '0;
    end
  end

  // ==========================================
  // checks
  chk_cts_de_delay: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(deOn) && $past(ctsEnable) |-> !$past(ctsN, 3))
    else $error("enable rose too soon after clear-to-send");

  chk_lead_time: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $fell(txd) && $past(state) == ST_LEAD |-> leadCnt == BIT_CLKS)
    else $error("start edge not one bit after enable");

  chk_de_release: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == ST_STOP && bitTick && lastStop && !goNext
    |=> deOn ##1 !deOn && txd)
    else $error("enable not released one clock after stop");

  chk_write_de: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !ctsEnable && state == ST_IDLE && fifoValid |=> deOn && state == ST_LEAD)
    else $error("write did not raise enable");

  chk_hold_b2b: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == ST_STOP && bitTick && lastStop && goNext
    |=> deOn && !txd && state == ST_START)
    else $error("enable dropped between characters");

  chk_cts_wait: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ctsEnable && !ctsLow && state == ST_IDLE |=> !deOn && txd)
    else $error("sent without clear-to-send");

  chk_de_polarity: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $past(state) == ST_IDLE && state == ST_IDLE |-> driverEnable != $past(dePolarity))
    else $error("idle enable level wrong");

  chk_frame_stop: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == ST_DATA && bitTick && lastData |=> txd [*2])
    else $error("stop bit not high");

endmodule
`default_nettype wire

// *** dv/line_xcvr_model.sv ***
// line transceiver and clear-to-send source
// assumes txd and driverEnable change on ref_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module line_xcvr_model #(
  parameter int BIT_CLKS = 4
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // line side
  input  wire logic       txd,
  input  wire logic       driverEnable,
  input  wire logic       dePolarity,
  output logic            ctsN,
  // bench side
  input  wire logic       holdOff,
  output logic [7:0]      rxData,
  output logic            rxStrobe,
  output logic            frameErr
);
  int   cnt;
  logic busy;

  // ====
  // clear-to-send follows the hold request
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) ctsN <= 1'h1;
    else ctsN <= holdOff;
  end

  // ====
  // receiver sampling mid-bit; sticky fault flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'h0;
      cnt <= 0;
      rxData <= 8'h00;
      rxStrobe <= 1'h0;
      frameErr <= 1'h0;
    end else begin
      rxStrobe <= 1'h0;
      if (!busy) begin
        if (txd === 1'h0) begin
          busy <= 1'h1;
          cnt <= 1;
          if (driverEnable !== dePolarity) frameErr <= 1'h1;
        end
      end else begin
        cnt <= cnt + 1;
        if (cnt % BIT_CLKS == BIT_CLKS / 2) begin
          if (cnt / BIT_CLKS == 0 && txd !== 1'h0) frameErr <= 1'h1;
          if (cnt / BIT_CLKS inside {[1:8]}) rxData <= {txd, rxData[7:1]};
          if (cnt / BIT_CLKS == 9) begin
            busy <= 1'h0;
            rxStrobe <= 1'h1;
            if (txd !== 1'h1) frameErr <= 1'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/test_uart_driver_enable_flow_control.sv ***
// self-checking bench for the driver-enable sequencer
// assumes line_xcvr_model on the line side, bit of 4 clocks
`timescale 1ns/1ps
`default_nettype none
module test_uart_driver_enable_flow_control;
  import uart_de_pkg::*;
  localparam int N = 4;
  logic       ref_clk = 1'h0;
  logic       rstn = 1'h0;
  logic       txWrite = 1'h0;
  logic [7:0] txData = 8'h00;
  logic       ctsEnable = 1'h0;
  logic       dePolarity = 1'h1;
  logic       stopTwo = 1'h0;
  logic       holdOff = 1'h1;
  logic       txReady;
  logic       ctsN;
  logic       txd;
  logic       driverEnable;
  txState_t   lineState;
  logic [7:0] rxData;
  logic       rxStrobe;
  logic       frameErr;
  logic [7:0] rxQ[$];
  int         error_cnt = 0;
  int         total_checks = 0;

  // ====
  // design, line model, clock, received-character log
  uart_driver_enable_flow_control #(.BIT_CLKS(N)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .txWrite(txWrite), .txData(txData), .txReady(txReady),
    .ctsEnable(ctsEnable), .dePolarity(dePolarity), .stopTwo(stopTwo), .ctsN(ctsN),
    .txd(txd), .driverEnable(driverEnable), .lineState(lineState));
  line_xcvr_model #(.BIT_CLKS(N)) xcvr (
    .ref_clk(ref_clk), .rstn(rstn), .txd(txd), .driverEnable(driverEnable),
    .dePolarity(dePolarity), .ctsN(ctsN), .holdOff(holdOff), .rxData(rxData),
    .rxStrobe(rxStrobe), .frameErr(frameErr));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rxStrobe === 1'h1) rxQ.push_back(rxData);

  // ====
  // shared helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic cond(input int what);
    case (what)
      0: return driverEnable === dePolarity;
      1: return txd === 1'h0;
      2: return driverEnable === !dePolarity;
      default: return ctsN === 1'h0;
    endcase
  endfunction
  // edges until the condition holds, bounded
  task automatic wait_for(input int what, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (!cond(what) && n < 2000);
  endtask
  task automatic put(input logic [7:0] d);
    @(posedge ref_clk);
    txWrite <= 1'h1;
    txData <= d;
  endtask
  task automatic stop_put();
    @(posedge ref_clk);
    txWrite <= 1'h0;
  endtask

  // ====
  // scenarios
  task automatic t_reset();
    repeat (12) @(posedge ref_clk);
    rstn <= 1'h1;
    @(posedge ref_clk);
    #1;
    check("idle enable", driverEnable, 1'h0);
    check("idle line", txd, 1'h1);
    check("ready", txReady, 1'h1);
    check("state", lineState, ST_IDLE);
  endtask
  task automatic t_frame(input logic pol, input logic two, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    dePolarity <= pol;
    stopTwo <= two;
    put(d);
    stop_put();
    wait_for(0, n);
    check("enable after write", n, 1);
    wait_for(1, n);
    check("lead", n, N);
    wait_for(2, n);
    check("release", n, (two ? 11 : 10) * N + 1);
    check("char", rxQ.pop_back(), d);
    check("idle level", driverEnable, !pol);
  endtask
  task automatic t_chain();
    int n;
    @(posedge ref_clk);
    dePolarity <= 1'h1;
    stopTwo <= 1'h0;
    put(8'h5A);
    put(8'hC3);
    stop_put();
    wait_for(0, n);
    wait_for(1, n);
    wait_for(2, n);
    check("span of two", n, 20 * N + 1);
    check("second char", rxQ.pop_back(), 8'hC3);
    check("first char", rxQ.pop_back(), 8'h5A);
  endtask
  task automatic t_cts();
    int n;
    @(posedge ref_clk);
    ctsEnable <= 1'h1;
    put(8'h96);
    stop_put();
    repeat (40) @(posedge ref_clk);
    #1;
    check("held enable", driverEnable, 1'h0);
    check("held state", lineState, ST_IDLE);
    @(posedge ref_clk);
    holdOff <= 1'h0;
    wait_for(3, n);
    wait_for(0, n);
    check("clear to enable", n >= 2 && n <= 2 + N, 1'h1);
    wait_for(1, n);
    check("lead after clear", n, N);
    wait_for(2, n);
    check("char", rxQ.pop_back(), 8'h96);
    @(posedge ref_clk);
    holdOff <= 1'h1;
    // let the clear-to-send delay line see the hold before new writes
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_fill();
    int n;
    for (int i = 0; i < 33; i++) put(i[7:0]);
    stop_put();
    #1;
    check("full", txReady, 1'h0);
    rxQ.delete();
    @(posedge ref_clk);
    holdOff <= 1'h0;
    wait_for(0, n);
    wait_for(2, n);
    check("span of 32", n, 321 * N + 1);
    check("count", rxQ.size(), 32);
    for (int i = 0; i < 32; i++) check("order", rxQ[i], i);
    check("ready again", txReady, 1'h1);
  endtask

  // ====
  // main sequence and watchdog
  initial begin
    t_reset();
    t_frame(1'h1, 1'h0, 8'hA5);
    t_frame(1'h0, 1'h1, 8'h3C);
    t_chain();
    t_cts();
    t_fill();
    check("line faults", frameErr, 1'h0);
    tally_and_finish();
  end
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
